// *** design/dmac_top.v ***
// dual multiply-accumulate path with an AHB-Lite register slave
// assumes single word transfers; one wait state on every transfer
`default_nettype none
`include "dmac_defines.vh"

module dmac_top #(
    parameter COEF_AW = 6
) (
    input wire clock,
    input wire rstn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg [31:0] hrdata,
    output reg hresp
);

    localparam ST_IDLE = 2'b01;
    localparam ST_RUN = 2'b10;
    localparam COEF_DEPTH = 1 << COEF_AW;

    function [COEF_AW-1:0] partnerOf;
        input [COEF_AW-1:0] ea;
        begin
            partnerOf = {ea[COEF_AW-1:1], ~ea[0]};
        end
    endfunction

    reg [5:0] ctrl_reg;
    reg [23:0] instr_reg;
    reg [15:0] xData_reg;
    reg [15:0] yData_reg;
    reg [COEF_AW-1:0] cPtr_reg;
    reg [7:0] cStep_reg;
    reg [3:0] ovf_reg;
    reg [3:0] ovf_next;
    reg [1:0] state_reg;
    reg [7:0] repLeft_reg;
    reg [39:0] acc [0:3];
    reg [15:0] coefMem [0:COEF_DEPTH-1];
    reg aValid_reg;
    reg aWrite_reg;
    reg [11:0] aAddr_reg;
    reg [31:0] readValue;
    integer i;

    wire accept = hsel & hready & htrans[1] & hreadyout;
    wire busWr = aValid_reg & aWrite_reg;
    wire isCoef = aAddr_reg[11:8] == `DMAC_OFF_COEF;
    wire [COEF_AW-1:0] coefIdx = aAddr_reg[COEF_AW+1:2];
    wire running = state_reg == ST_RUN;

    wire form = instr_reg[`DMAC_IN_FORM];
    wire [1:0] plainDst = instr_reg[`DMAC_IN_PDST_LO+1:`DMAC_IN_PDST_LO];
    wire [1:0] macDst = instr_reg[`DMAC_IN_MDST_LO+1:`DMAC_IN_MDST_LO];
    wire macEn = running & ~instr_reg[`DMAC_IN_OFF_MAC];
    wire plainEn = running & ~instr_reg[`DMAC_IN_OFF_MPY];
    // forced wide mode never touches the stored control bit
    wire m40Eff = ctrl_reg[`DMAC_CTRL_M40] |
        instr_reg[`DMAC_IN_Q40];
    wire [COEF_AW-1:0] partner = partnerOf(cPtr_reg);

    // shared form: the X operand feeds both units
    wire [15:0] macData = form ? xData_reg : yData_reg;
    wire [15:0] plainCoef = coefMem[cPtr_reg];
    wire [15:0] macCoef = form ?
        coefMem[partner] : coefMem[cPtr_reg];
    wire [39:0] plainRes;
    wire [39:0] macRes;
    wire plainOvf;
    wire macOvf;

    // unit one accumulates, unit two does the plain multiply
    dmac_lane u_one (
        .opData(macData),
        .opCoef(macCoef),
        .unsData(instr_reg[`DMAC_IN_UNS_MD]),
        .unsCoef(instr_reg[`DMAC_IN_UNS_MC]),
        .sign_extension_mode_bit(ctrl_reg[`DMAC_CTRL_SIGN_EXTENSION_MODE_BIT]),
        .fractional_mode_bit(ctrl_reg[`DMAC_CTRL_FRACTIONAL_MODE_BIT]),
        .multiply_saturate_control(ctrl_reg[`DMAC_CTRL_MULTIPLY_SATURATE_CONTROL]),
        .rounding_mode_bit(ctrl_reg[`DMAC_CTRL_RDM]),
        .rnd(instr_reg[`DMAC_IN_RND]),
        .m40(m40Eff),
        .saturation_mode_bit(ctrl_reg[`DMAC_CTRL_SATURATION_MODE_BIT]),
        .accum(1'b1),
        .preShift(~form),
        .srcAcc(acc[macDst]),
        .result(macRes),
        .ovf(macOvf)
    );

    dmac_lane u_two (
        .opData(xData_reg),
        .opCoef(plainCoef),
        .unsData(instr_reg[`DMAC_IN_UNS_PD]),
        .unsCoef(instr_reg[`DMAC_IN_UNS_PC]),
        .sign_extension_mode_bit(ctrl_reg[`DMAC_CTRL_SIGN_EXTENSION_MODE_BIT]),
        .fractional_mode_bit(ctrl_reg[`DMAC_CTRL_FRACTIONAL_MODE_BIT]),
        .multiply_saturate_control(ctrl_reg[`DMAC_CTRL_MULTIPLY_SATURATE_CONTROL]),
        .rounding_mode_bit(ctrl_reg[`DMAC_CTRL_RDM]),
        .rnd(instr_reg[`DMAC_IN_RND]),
        .m40(m40Eff),
        .saturation_mode_bit(ctrl_reg[`DMAC_CTRL_SATURATION_MODE_BIT]),
        .accum(1'b0),
        .preShift(1'b0),
        .srcAcc(40'h0000000000),
        .result(plainRes),
        .ovf(plainOvf)
    );

    // status flags: hardware set wins over a software clear
    always @*
    begin
        ovf_next = ovf_reg;
        if (busWr && aAddr_reg == `DMAC_OFF_STATUS)
        begin
            ovf_next = ovf_next & ~hwdata[3:0];
        end
        if (plainEn && plainOvf)
        begin
            ovf_next[plainDst] = 1'b1;
        end
        if (macEn && macOvf)
        begin
            ovf_next[macDst] = 1'b1;
        end
    end

    always @*
    begin
        readValue = 32'h00000000;
        if (isCoef)
        begin
            readValue = {16'h0000, coefMem[coefIdx]};
        end
        else
        begin
            case (aAddr_reg)
                `DMAC_OFF_CTRL: readValue = {26'h0000000, ctrl_reg};
                `DMAC_OFF_INSTR: readValue = {8'h00, instr_reg};
                `DMAC_OFF_GO: readValue = {31'h00000000, running};
                `DMAC_OFF_STATUS: readValue = {28'h0000000, ovf_reg};
                `DMAC_OFF_XDATA: readValue = {16'h0000, xData_reg};
                `DMAC_OFF_YDATA: readValue = {16'h0000, yData_reg};
                `DMAC_OFF_CPTR: readValue = {{(32-COEF_AW){1'b0}}, cPtr_reg};
                `DMAC_OFF_CSTEP: readValue = {24'h000000, cStep_reg};
                `DMAC_OFF_PARTNER: readValue = {{(32-COEF_AW){1'b0}}, partner};
                12'h020: readValue = acc[0][31:0];
                12'h024: readValue = {24'h000000, acc[0][39:32]};
                12'h028: readValue = acc[1][31:0];
                12'h02c: readValue = {24'h000000, acc[1][39:32]};
                12'h030: readValue = acc[2][31:0];
                12'h034: readValue = {24'h000000, acc[2][39:32]};
                12'h038: readValue = acc[3][31:0];
                12'h03c: readValue = {24'h000000, acc[3][39:32]};
                default: readValue = 32'h00000000;
            endcase
        end
    end

    // bus slave: accept, then one wait state while the access is done
    // registered outputs cost a cycle but keep hrdata glitch free
    always @(posedge clock)
    begin
        if (!rstn)
        begin
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
            aValid_reg <= 1'b0;
            aWrite_reg <= 1'b0;
            aAddr_reg <= 12'h000;
        end
        else if (accept)
        begin
            hreadyout <= 1'b0;
            aValid_reg <= 1'b1;
            aWrite_reg <= hwrite;
            aAddr_reg <= {haddr[11:2], 2'b00};
        end
        else if (aValid_reg)
        begin
            hreadyout <= 1'b1;
            aValid_reg <= 1'b0;
            if (!aWrite_reg)
            begin
                hrdata <= readValue;
            end
        end
    end

    // coefficient store, software loaded; no reset needed for data
    always @(posedge clock)
    begin
        if (busWr && isCoef)
        begin
            coefMem[coefIdx] <= hwdata[15:0];
        end
    end

    always @(posedge clock)
    begin
        if (!rstn)
        begin
            ctrl_reg <= `DMAC_CTRL_RESET;
            instr_reg <= `DMAC_INSTR_RESET;
            xData_reg <= 16'h0000;
            yData_reg <= 16'h0000;
            cStep_reg <= 8'h00;
            ovf_reg <= 4'h0;
        end
        else
        begin
            ovf_reg <= ovf_next;
            if (busWr)
            begin
                case (aAddr_reg)
                    `DMAC_OFF_CTRL: ctrl_reg <= hwdata[5:0];
                    `DMAC_OFF_INSTR: instr_reg <= hwdata[23:0];
                    `DMAC_OFF_XDATA: xData_reg <= hwdata[15:0];
                    `DMAC_OFF_YDATA: yData_reg <= hwdata[15:0];
                    `DMAC_OFF_CSTEP: cStep_reg <= hwdata[7:0];
                    default: ctrl_reg <= ctrl_reg;
                endcase
            end
        end
    end

    // sequencer: one paired operation per cycle for repeat+1 cycles
    always @(posedge clock)
    begin
        if (!rstn)
        begin
            state_reg <= ST_IDLE;
            repLeft_reg <= 8'h00;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (busWr && aAddr_reg == `DMAC_OFF_GO && hwdata[0])
                    begin
                        state_reg <= ST_RUN;
                        repLeft_reg <= instr_reg[`DMAC_IN_REP_LO+7:
                            `DMAC_IN_REP_LO];
                    end
                end
                ST_RUN:
                begin
                    if (repLeft_reg == 8'h00)
                    begin
                        state_reg <= ST_IDLE;
                    end
                    else
                    begin
                        repLeft_reg <= repLeft_reg - 8'h01;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // pointer advances every operation, even with both units idle
    always @(posedge clock)
    begin
        if (!rstn)
        begin
            cPtr_reg <= {COEF_AW{1'b0}};
        end
        else if (running)
        begin
            cPtr_reg <= cPtr_reg + cStep_reg[COEF_AW-1:0];
        end
        else if (busWr && aAddr_reg == `DMAC_OFF_CPTR)
        begin
            cPtr_reg <= hwdata[COEF_AW-1:0];
        end
    end

    // accumulators: execution overrides a bus write in the same cycle
    always @(posedge clock)
    begin
        if (!rstn)
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                acc[i] <= 40'h0000000000;
            end
        end
        else
        begin
            if (busWr && aAddr_reg[11:5] == 7'h01)
            begin
                if (aAddr_reg[2])
                begin
                    acc[aAddr_reg[4:3]][39:32] <= hwdata[7:0];
                end
                else
                begin
                    acc[aAddr_reg[4:3]][31:0] <= hwdata;
                end
            end
            if (plainEn)
            begin
                acc[plainDst] <= plainRes;
            end
            if (macEn)
            begin
                acc[macDst] <= macRes;
            end
        end
    end

endmodule
`default_nettype wire

// *** design/dmac_defines.vh ***
// constants of the dual multiply-accumulate path: register offsets,
// field positions, reset values and arithmetic limits
`ifndef DMAC_DEFINES_VH
`define DMAC_DEFINES_VH

`define DMAC_OFF_CTRL     12'h000
`define DMAC_OFF_INSTR    12'h004
`define DMAC_OFF_GO       12'h008
`define DMAC_OFF_STATUS   12'h00c
`define DMAC_OFF_XDATA    12'h010
`define DMAC_OFF_YDATA    12'h014
`define DMAC_OFF_CPTR     12'h018
`define DMAC_OFF_CSTEP    12'h01c
`define DMAC_OFF_PARTNER  12'h040
`define DMAC_OFF_ACC      12'h020
`define DMAC_ACC_STRIDE   12'h008
`define DMAC_OFF_COEF     4'h1

`define DMAC_CTRL_FRACTIONAL_MODE_BIT    0
`define DMAC_CTRL_MULTIPLY_SATURATE_CONTROL    1
`define DMAC_CTRL_RDM     2
`define DMAC_CTRL_M40     3
`define DMAC_CTRL_SATURATION_MODE_BIT    4
`define DMAC_CTRL_SIGN_EXTENSION_MODE_BIT    5
`define DMAC_CTRL_RESET   6'h20

`define DMAC_IN_FORM      0
`define DMAC_IN_RND       1
`define DMAC_IN_Q40       2
`define DMAC_IN_UNS_PD    3
`define DMAC_IN_UNS_MD    4
`define DMAC_IN_UNS_PC    5
`define DMAC_IN_UNS_MC    6
`define DMAC_IN_OFF_MAC   7
`define DMAC_IN_OFF_MPY   8
`define DMAC_IN_PDST_LO   9
`define DMAC_IN_MDST_LO   11
`define DMAC_IN_REP_LO    16
`define DMAC_INSTR_RESET  24'h000000

`define DMAC_RND_BIAS     41'h00000008000
`define DMAC_SAT40_POS    40'h7fffffffff
`define DMAC_SAT40_NEG    40'h8000000000
`define DMAC_SAT32_POS    40'h007fffffff
`define DMAC_SAT32_NEG    40'hff80000000
`define DMAC_MULTIPLY_SATURATE_CONTROL_OPND    17'h18000
`define DMAC_MULTIPLY_SATURATE_CONTROL_SAT     32'h7fffffff

`endif

// *** design/dmac_lane.v ***
// one multiplier unit: operand widening, product, optional accumulate,
// rounding, overflow check and saturation; purely combinational
// assumes the caller registers the result into its accumulator
`default_nettype none
`include "dmac_defines.vh"

module dmac_lane (
    input wire [15:0] opData,
    input wire [15:0] opCoef,
    input wire unsData,
    input wire unsCoef,
    input wire sign_extension_mode_bit,
    input wire fractional_mode_bit,
    input wire multiply_saturate_control,
    input wire rounding_mode_bit,
    input wire rnd,
    input wire m40,
    input wire saturation_mode_bit,
    input wire accum,
    input wire preShift,
    input wire [39:0] srcAcc,
    output wire [39:0] result,
    output wire ovf
);

    function [16:0] ext17;
        input [15:0] v;
        input uns;
        input sx;
        begin
            ext17 = {(~uns & sx) & v[15], v};
        end
    endfunction

    wire signed [16:0] aExt = ext17(opData, unsData, sign_extension_mode_bit);
    wire signed [16:0] bExt = ext17(opCoef, unsCoef, sign_extension_mode_bit);
    wire signed [33:0] prod = aExt * bExt;
    wire [33:0] prodSh = fractional_mode_bit ? {prod[32:0], 1'b0} : prod;
    // only -1.0 * -1.0 can overflow a fractional product
    wire smulHit = multiply_saturate_control & fractional_mode_bit & (aExt == `DMAC_MULTIPLY_SATURATE_CONTROL_OPND) &
        (bExt == `DMAC_MULTIPLY_SATURATE_CONTROL_OPND);
    wire [31:0] prod32 = smulHit ? `DMAC_MULTIPLY_SATURATE_CONTROL_SAT : prodSh[31:0];
    wire [40:0] prod41 = {{9{prod32[31]}}, prod32};
    wire [39:0] srcSh = preShift ?
        {{16{srcAcc[39]}}, srcAcc[39:16]} : srcAcc;
    wire [40:0] sum41 = accum ? {srcSh[39], srcSh} + prod41 : prod41;
    wire [40:0] rsum = sum41 + `DMAC_RND_BIAS;
    wire tie = rounding_mode_bit & (sum41[15:0] == 16'h8000);
    wire [40:0] rval = !rnd ? sum41 :
        tie ? {rsum[40:17], 17'h00000} : {rsum[40:16], 16'h0000};
    // 41 bits hold the true sign for the saturation direction
    assign ovf = m40 ? (rval[40] != rval[39]) :
        !((&rval[40:31]) | ~(|rval[40:31]));
    wire [39:0] satVal = m40 ?
        (rval[40] ? `DMAC_SAT40_NEG : `DMAC_SAT40_POS) :
        (rval[40] ? `DMAC_SAT32_NEG : `DMAC_SAT32_POS);
    assign result = (ovf & saturation_mode_bit) ? satVal : rval[39:0];

endmodule
`default_nettype wire

// *** dv/dmac_top_assertions.sv ***
// assertions on the register slave ports of the dual mac path
// bound onto dmac_top by the bench; one clock, synchronous reset
`default_nettype none
module dmac_top_assertions #(
    parameter COEF_AW = 6
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    wire logic taken = hsel && hready && htrans[1] && hreadyout;
    wire logic takenRd = taken && !hwrite;
    // holes between the partner word and the coefficient store
    wire logic gapRd = takenRd && haddr[11:2] > 10'h10 && haddr[11:2] < 10'h40;
    wire logic statRd = takenRd && haddr[11:0] == 12'h00c;
    property p_okay; hresp == 1'b0; endproperty
    property p_wait; taken |=> !hreadyout ##1 hreadyout; endproperty
    property p_short; !hreadyout |=> hreadyout; endproperty
    property p_idle; hreadyout && !taken |=> hreadyout; endproperty
    property p_rst; $rose(rstn) |-> hreadyout && hrdata == 32'h0; endproperty
    property p_hold; !$past(takenRd, 2) |-> $stable(hrdata); endproperty
    property p_gap; gapRd |=> ##1 hrdata == 32'h0; endproperty
    property p_stat; statRd |=> ##1 hrdata[31:4] == 28'h0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    a_wait: assert property (p_wait) else $error("wait state wrong");
    a_short: assert property (p_short) else $error("wait too long");
    a_idle: assert property (p_idle) else $error("stall without transfer");
    a_rst: assert property (p_rst) else $error("bad reset outputs");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_gap: assert property (p_gap) else $error("hole read not zero");
    a_stat: assert property (p_stat) else $error("flag bits wide");
    c_wr: cover property (taken && hwrite);
    c_rd: cover property (takenRd ##2 hrdata != 32'h0);
    c_gap: cover property (gapRd);
endmodule
`default_nettype wire

// *** dv/dmac_ahb_master.sv ***
// bus master model standing in for the decoder side of the path
// single word transfers only; hready is the one slave's hreadyout
`default_nettype none
module dmac_ahb_master (
    input wire logic clock,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output var logic hsel,
    output var logic [31:0] haddr,
    output var logic [1:0] htrans,
    output var logic hwrite,
    output var logic [2:0] hsize,
    output var logic [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
    end
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clock); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        r = hrdata;
        // released data must not keep looking valid
        hwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// *** dv/dmac_top_tb_top.sv ***
// bench top for the dual multiply-accumulate path
// all traffic goes through the bus master model; checker bound below
`default_nettype none
module dmac_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    wire logic hsel, hwrite, hreadyout, hresp;
    wire logic [31:0] haddr, hwdata, hrdata;
    wire logic [1:0] htrans;
    wire logic [2:0] hsize;
    int nFail = 0;
    int checksDone = 0;
    int cycles = 0;
    always #50 clock = ~clock;
    dmac_top #(.COEF_AW(6)) u_dmac_top (.clock(clock), .rstn(rstn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
    dmac_ahb_master u_dmac_ahb_master (.clock(clock), .hready(hreadyout),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    task automatic results;
        $display("checks %0d, mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [39:0] s, input logic [39:0] e);
        checksDone++;
        if (s !== e)
        begin
            nFail++;
            $display("unexpected at %0t ns: saw %h, want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        u_dmac_ahb_master.xfer({20'h0, a}, 1'b1, d, r);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        u_dmac_ahb_master.xfer({20'h0, a}, 1'b0, 32'h0, r);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        rd(a, r);
        chk({8'h0, r}, {8'h0, e});
    endtask
    task automatic acc(input logic [1:0] n, input logic [39:0] e);
        logic [31:0] lo, hi;
        rd(12'h020 + {7'h0, n, 3'h0}, lo);
        rd(12'h024 + {7'h0, n, 3'h0}, hi);
        chk({hi[7:0], lo}, e);
    endtask
    task automatic setAcc(input logic [1:0] n, input logic [39:0] v);
        wr(12'h020 + {7'h0, n, 3'h0}, v[31:0]);
        wr(12'h024 + {7'h0, n, 3'h0}, {24'h0, v[39:32]});
    endtask
    task automatic coef(input logic [5:0] k, input logic [15:0] v);
        wr(12'h100 + {4'h0, k, 2'h0}, {16'h0, v});
    endtask
    task automatic setup(input logic [15:0] x, input logic [15:0] y,
                         input logic [5:0] p, input logic [7:0] s);
        wr(12'h010, {16'h0, x});
        wr(12'h014, {16'h0, y});
        wr(12'h018, {26'h0, p});
        wr(12'h01c, {24'h0, s});
    endtask
    // polls busy rather than assuming a cycle count
    task automatic op(input logic [5:0] ctrl, input logic [23:0] instr);
        logic [31:0] r;
        wr(12'h000, {26'h0, ctrl});
        wr(12'h004, {8'h0, instr});
        wr(12'h008, 32'h1);
        r = 32'h1;
        while (r[0] !== 1'b0)
            rd(12'h008, r);
    endtask
    task automatic tReset;
        rchk(12'h000, 32'h20);
        rchk(12'h00c, 32'h0);
        rchk(12'h044, 32'h0);
        $display("reset test done");
    endtask
    task automatic tSingle;
        coef(6'd0, 16'h0005);
        setup(16'h0003, 16'hfffe, 6'd0, 8'd0);
        setAcc(2'd1, 40'h8000000000);
        op(6'h20, 24'h000800);
        acc(2'd0, 40'h000000000f);
        acc(2'd1, 40'hffff7ffff6);
        acc(2'd2, 40'h0);
        acc(2'd3, 40'h0);
        rchk(12'h00c, 32'h0);
        $display("single form test done");
    endtask
    task automatic tShared;
        coef(6'd2, 16'h0100);
        coef(6'd3, 16'h0003);
        setup(16'h0004, 16'h0007, 6'd2, 8'd0);
        setAcc(2'd3, 40'h100);
        op(6'h20, 24'h001c01);
        acc(2'd2, 40'h400);
        acc(2'd3, 40'h10c);
        rchk(12'h040, 32'h3);
        wr(12'h018, 32'h3);
        rchk(12'h040, 32'h2);
        $display("shared form test done");
    endtask
    task automatic tFrac;
        coef(6'd4, 16'h0002);
        setup(16'hffff, 16'h0007, 6'd4, 8'd1);
        op(6'h21, 24'h0008a8);
        acc(2'd0, 40'h3fffc);
        acc(2'd1, 40'hffff7ffff6);
        rchk(12'h018, 32'h5);
        $display("fraction test done");
    endtask
    task automatic tOverflow;
        coef(6'd6, 16'h0001);
        coef(6'd7, 16'h0001);
        setup(16'h7fff, 16'h0000, 6'd6, 8'd0);
        setAcc(2'd1, 40'h007fffffff);
        op(6'h30, 24'h000805);
        acc(2'd1, 40'h0080007ffe);
        rchk(12'h00c, 32'h0);
        setAcc(2'd1, 40'h007fffffff);
        op(6'h30, 24'h000801);
        acc(2'd1, 40'h007fffffff);
        rchk(12'h00c, 32'h2);
        rchk(12'h000, 32'h30);
        wr(12'h00c, 32'h2);
        rchk(12'h00c, 32'h0);
        $display("overflow test done");
    endtask
    task automatic tRound;
        coef(6'd6, 16'h4000);
        setup(16'h0002, 16'h7fff, 6'd6, 8'd0);
        for (int i = 0; i < 2; i++)
        begin
            op(i ? 6'h24 : 6'h20, 24'h000082);
            acc(2'd0, i ? 40'h0 : 40'h10000);
        end
        coef(6'd6, 16'h8000);
        setup(16'h8000, 16'h0000, 6'd6, 8'd0);
        op(6'h23, 24'h000080);
        acc(2'd0, 40'h007fffffff);
        $display("round test done");
    endtask
    task automatic tRepeat;
        for (int k = 0; k < 6; k++)
            coef(6'(k), k[0] ? 16'((k + 1) / 2) : 16'h0007);
        setup(16'h0001, 16'h0000, 6'd0, 8'd2);
        setAcc(2'd3, 40'h0);
        op(6'h20, 24'h021c01);
        acc(2'd2, 40'h7);
        acc(2'd3, 40'h6);
        rchk(12'h018, 32'h6);
        $display("repeat test done");
    endtask
    initial
    begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        tReset();
        tSingle();
        tShared();
        tFrac();
        tOverflow();
        tRound();
        tRepeat();
        results();
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            nFail++;
            $display("unexpected at %0t ns: run hung", $time);
            results();
        end
    end
endmodule
bind dmac_top dmac_top_assertions #(.COEF_AW(COEF_AW)) u_dmac_top_assertions (
    .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
`default_nettype wire
